// [rtl/twr_regs.svh]
`ifndef TWR_REGS_SVH
`define TWR_REGS_SVH
// How it works
// - Eight-bit registers; addresses 0 to 22 read, only 0 to 21 write.
// - Select is active high; clock and data are ignored while it is low.
// - As an input, one data bit is taken on each serial clock fall.
// - As an output, each read bit appears after a serial clock rise.
// - First byte: seven address bits MSB first, then direction, 1 reads.
// - One or more data bytes follow, MSB first, in the chosen direction.
// - Write data goes to consecutive addresses from the start address.
// - Written bytes wait in prebuffers and commit together on select fall.
// - After the read direction bit, the next clock rise drives data out.
// - Each further eight clocks return the next consecutive register.
// - Select falling at the end of a read releases the data line.
// - A write transaction never drives the data line.
// - After power-on the two mode bits of register 0 are zero.

`define TWR_NUM_RD        23
`define TWR_NUM_WR        22
`define TWR_ADDR_W        7
`define TWR_ADDR_LAST     7'h7F
`define TWR_DIR_READ      1'b1
`define TWR_REG_RESET     8'h00
`define TWR_MODE_LSB      1
`define TWR_MODE_MSB      2
`define TWR_LAST_BIT      3'h7

`define TWR_LNA_PA_MODE_CONTROL        7'h00
`define TWR_MODULATION_RSSI_FILTER_CFG 7'h01
`define TWR_PUMP_BYPASS_OUTPUT_SELECT  7'h02
`define TWR_OSCILLATOR_BIAS_RANGE      7'h03
`define TWR_MODULATOR_FRAC_INT         7'h04
`define TWR_MODULATOR_AMPLITUDE        7'h05
`define TWR_CLOCK_DIVIDER_SELECT       7'h06
`define TWR_BITRATE_REFERENCE_DIVIDER  7'h07
`define TWR_SWITCHED_CAP_CLOCK         7'h08
`define TWR_CRYSTAL_TRIM               7'h09
`define TWR_SYNTH_SET0_A_COUNT         7'h0A
`define TWR_SYNTH_SET0_N_HIGH          7'h0B
`define TWR_SYNTH_SET0_N_LOW           7'h0C
`define TWR_SYNTH_SET0_M_HIGH          7'h0D
`define TWR_SYNTH_SET0_M_LOW           7'h0E
`define TWR_SYNTH_SET1_A_COUNT         7'h0F
`define TWR_SYNTH_SET1_N_HIGH          7'h10
`define TWR_SYNTH_SET1_N_LOW           7'h11
`define TWR_SYNTH_SET1_M_HIGH          7'h12
`define TWR_SYNTH_SET1_M_LOW           7'h13
`define TWR_FIXED_CONFIGURATION        7'h14
`define TWR_FREQ_ERROR_CONTROL         7'h15
`define TWR_FREQ_ERROR_RESULT          7'h16
`endif

// [rtl/twr_pkg.sv]
`include "twr_regs.svh"

package twr_pkg;

    typedef enum logic [1:0] {
        TWR_PH_ADDR  = 2'b00,
        TWR_PH_WRITE = 2'b01,
        TWR_PH_READ  = 2'b10
    } twr_phase_t;

    typedef logic [`TWR_NUM_WR-1:0][7:0] twr_bank_t;

    typedef struct packed {
        twr_phase_t phase;
        logic [2:0] bit_cnt;
        logic [6:0] addr;
        logic [6:0] shift;
    } twr_rx_t;

    typedef struct packed {
        twr_bank_t               data;
        logic [`TWR_NUM_WR-1:0]  dirty;
    } twr_pre_t;

    typedef struct packed {
        logic       oe;
        logic       dout;
        logic [2:0] cnt;
        logic [6:0] shift;
    } twr_tx_t;

    typedef struct packed {
        logic [2:0] cs_sync;
        logic       commit;
        logic [7:0] fee;
        twr_bank_t  work;
    } twr_sys_t;

endpackage : twr_pkg

// [rtl/twr_port.sv]
`timescale 1ns/1ps
`include "twr_regs.svh"

module twr_port
    import twr_pkg::*;
(
    input  wire logic                      CLK_SYS_I,     // System clock.
    input  wire logic                      RESET_N_I,     // Async reset.
    input  wire logic                      SCLK_I,        // Serial clock.
    input  wire logic                      CS_I,          // Select, high.
    input  wire logic                      IO_I,          // Data line in.
    output logic                           IO_O,          // Data line out.
    output logic                           IO_OE_O,       // Data drive on.
    input  wire logic [7:0]                FEE_RESULT_I,  // Read-only value.
    output logic [`TWR_NUM_WR*8-1:0]       CFG_O,         // Working regs.
    output logic [1:0]                     MODE_O,        // Operating mode.
    output logic                           COMMIT_O,      // Commit pulse.
    output logic                           BUSY_O         // Select seen.
);

    // Link logic is held in reset whenever select is low, so edges on the
    // shared clock and data lines outside our own frame do nothing, and a
    // byte cut short by select falling is simply discarded.
    logic     link_rst_n;
    twr_rx_t  rx_q;
    twr_rx_t  rx_d;
    twr_pre_t pre_q;
    twr_pre_t pre_d;
    twr_tx_t  tx_q;
    twr_tx_t  tx_d;
    twr_sys_t sys_q;
    twr_sys_t sys_d;

    assign link_rst_n = CS_I & RESET_N_I;

    // Saturate so a long burst never wraps back onto real registers.
    function automatic logic [6:0] next_addr(input logic [6:0] a);
        logic [6:0] n;
        n = a;
        if (a != `TWR_ADDR_LAST) begin
            n = a + 7'h01;
        end
        return n;
    endfunction

    // Shared by the write path and the read mux so both agree on the
    // boundary between working registers and the read-only tail.
    function automatic logic is_writable(input logic [6:0] a);
        return a < 7'(`TWR_NUM_WR);
    endfunction

    function automatic logic [7:0] rd_byte(
        input logic [6:0] a,
        input twr_bank_t  bank,
        input logic [7:0] fee
    );
        logic [7:0] b;
        b = 8'h00;
        if (is_writable(a)) begin
            b = bank[a[4:0]];
        end else if (a == `TWR_FREQ_ERROR_RESULT) begin
            b = fee;
        end else begin
            b = 8'h00;
        end
        return b;
    endfunction

    // Receive side: runs on the falling serial clock edge.
    always_comb begin
        logic [7:0] byte_in;
        byte_in = {rx_q.shift, IO_I};
        rx_d = rx_q;
        pre_d = pre_q;
        rx_d.shift = byte_in[6:0];
        rx_d.bit_cnt = rx_q.bit_cnt + 3'h1;
        if (rx_q.bit_cnt == `TWR_LAST_BIT) begin
            case (rx_q.phase)
                TWR_PH_ADDR: begin
                    rx_d.addr = rx_q.shift;
                    if (IO_I == `TWR_DIR_READ) begin
                        rx_d.phase = TWR_PH_READ;
                    end else begin
                        rx_d.phase = TWR_PH_WRITE;
                        pre_d.dirty = '0;
                    end
                end
                TWR_PH_WRITE: begin
                    if (is_writable(rx_q.addr)) begin
                        pre_d.data[rx_q.addr[4:0]] = byte_in;
                        pre_d.dirty[rx_q.addr[4:0]] = 1'b1;
                    end
                    rx_d.addr = next_addr(rx_q.addr);
                end
                TWR_PH_READ: begin
                    rx_d.addr = next_addr(rx_q.addr);
                end
                default: begin
                    rx_d.phase = TWR_PH_ADDR;
                end
            endcase
        end
    end

    always_ff @(negedge SCLK_I or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_q <= '{phase: TWR_PH_ADDR, default: '0};
        end else begin
            rx_q <= rx_d;
        end
    end

    // The prebuffers survive select falling; the system side copies them
    // out after select low has been synchronised, and no serial clock edge
    // can move them again until the host opens the next frame.
    always_ff @(negedge SCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_d;
        end
    end

    // Transmit side: runs on the rising serial clock edge.
    always_comb begin
        logic [7:0] byte_out;
        byte_out = 8'h00;
        tx_d = tx_q;
        if (rx_q.phase == TWR_PH_READ) begin
            tx_d.oe = 1'b1;
            if (tx_q.cnt == 3'h0) begin
                byte_out = rd_byte(rx_q.addr, sys_q.work, sys_q.fee);
                tx_d.dout = byte_out[7];
                tx_d.shift = byte_out[6:0];
                tx_d.cnt = `TWR_LAST_BIT;
            end else begin
                tx_d.dout = tx_q.shift[6];
                tx_d.shift = {tx_q.shift[5:0], 1'b0};
                tx_d.cnt = tx_q.cnt - 3'h1;
            end
        end else begin
            tx_d.oe = 1'b0;
        end
    end

    // The output enable clears the instant select falls, without waiting
    // for a clock edge that may never come.
    always_ff @(posedge SCLK_I or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_q <= '0;
        end else begin
            tx_q <= tx_d;
        end
    end

    assign IO_O = tx_q.dout;
    assign IO_OE_O = tx_q.oe;

    // System side. Working registers and the read-only snapshot change only
    // while select is seen low, so the serial side reads them as stable
    // words during a frame. The limitation is that the snapshot is as old
    // as the last idle moment before the frame opened.
    always_comb begin
        sys_d = sys_q;
        sys_d.cs_sync = {sys_q.cs_sync[1:0], CS_I};
        sys_d.commit = 1'b0;
        if (sys_q.cs_sync[2] && !sys_q.cs_sync[1]) begin
            sys_d.commit = 1'b1;
            for (int i = 0; i < `TWR_NUM_WR; i++) begin
                if (pre_q.dirty[i]) begin
                    sys_d.work[i] = pre_q.data[i];
                end
            end
        end
        if (!sys_q.cs_sync[1] && !sys_q.cs_sync[2]) begin
            sys_d.fee = FEE_RESULT_I;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sys_q <= '{work: {`TWR_NUM_WR{`TWR_REG_RESET}}, default: '0};
        end else begin
            sys_q <= sys_d;
        end
    end

    assign CFG_O = sys_q.work;
    assign MODE_O = sys_q.work[0][`TWR_MODE_MSB:`TWR_MODE_LSB];
    assign COMMIT_O = sys_q.commit;
    assign BUSY_O = sys_q.cs_sync[2];

endmodule // twr_port

// [verif/twr_port_checker.sv]
`timescale 1ns/1ps
`include "twr_regs.svh"
module twr_port_checker (
    input wire logic                      CLK_SYS_I,
    input wire logic                      RESET_N_I,
    input wire logic                      SCLK_I,
    input wire logic                      CS_I,
    input wire logic                      IO_I,
    input wire logic                      IO_O,
    input wire logic                      IO_OE_O,
    input wire logic [7:0]                FEE_RESULT_I,
    input wire logic [`TWR_NUM_WR*8-1:0]  CFG_O,
    input wire logic [1:0]                MODE_O,
    input wire logic                      COMMIT_O,
    input wire logic                      BUSY_O
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RESET_N_I);
    oe_off_a: assert property (!CS_I |-> !IO_OE_O)
        else $error("Data line driven while deselected.");
    oe_rise_a: assert property ($rose(IO_OE_O) |-> SCLK_I && BUSY_O)
        else $error("Data line turned on at a wrong moment.");
    bit_hold_a: assert property (CS_I && $past(CS_I) && !SCLK_I &&
        !$past(SCLK_I) |-> $stable(IO_O))
        else $error("Read bit moved while the serial clock stayed low.");
    busy_up_a: assert property ($rose(CS_I) |-> ##[1:4] BUSY_O)
        else $error("Select not seen in time.");
    busy_down_a: assert property ($fell(CS_I) |-> ##[1:4] !BUSY_O)
        else $error("Select release not seen in time.");
    commit_one_a: assert property (COMMIT_O |=> !COMMIT_O)
        else $error("Commit pulse longer than one cycle.");
    commit_idle_a: assert property (COMMIT_O |-> !CS_I)
        else $error("Commit while selected.");
    cfg_hold_a: assert property (!COMMIT_O |-> $stable(CFG_O))
        else $error("Working registers changed outside commit.");
    mode_map_a: assert property (MODE_O == CFG_O[2:1])
        else $error("Mode output differs from register 0.");
    mode_reset_a: assert property ($rose(RESET_N_I) |-> MODE_O == 2'h0)
        else $error("Mode field not zero after reset.");
endmodule // twr_port_checker
bind twr_port twr_port_checker i_chk (.CLK_SYS_I, .RESET_N_I, .SCLK_I,
    .CS_I, .IO_I, .IO_O, .IO_OE_O, .FEE_RESULT_I, .CFG_O, .MODE_O,
    .COMMIT_O, .BUSY_O);

// [verif/twr_host.sv]
`timescale 1ns/1ps
module twr_host (
    input  wire logic io_i,    // Resolved data line.
    output logic      sclk_o,  // Serial clock, 48 ns period.
    output logic      cs_o,    // Select.
    output logic      io_o     // Host data drive.
);
    initial begin
        sclk_o = 1'h0;
        cs_o = 1'h0;
        io_o = 1'h0;
    end
    // Select only moves while the serial clock rests low.
    task automatic cs_set(input logic v);
        #13 cs_o = v;
        #37;
    endtask
    // While released the host toggles its level, so a stale bit never
    // passes for device data.
    task automatic xfer(input logic [7:0] tx, input logic rd,
                        output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk_o = 1'h1;
            io_o = rd ? ~io_o : tx[i];
            #24 rx[i] = io_i;
            sclk_o = 1'h0;
            #24;
        end
    endtask
endmodule // twr_host

// [verif/three_wire_register_port_bench.sv]
`timescale 1ns/1ps
`include "twr_regs.svh"
module three_wire_register_port_bench;
    logic                     clk_sys, reset_n, sclk, cs, h_io;
    logic                     io_out, io_oe, commit, busy;
    logic [1:0]               mode;
    logic [7:0]               fee, rx;
    logic [`TWR_NUM_WR*8-1:0] cfg;
    logic [7:0]               mem [0:127];
    int                       error_cnt, cmp_count, commit_cnt;
    wire                      io_line = io_oe ? io_out : h_io;
    twr_port i_dut (
        .CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .SCLK_I(sclk),
        .CS_I(cs), .IO_I(io_line), .IO_O(io_out), .IO_OE_O(io_oe),
        .FEE_RESULT_I(fee), .CFG_O(cfg), .MODE_O(mode),
        .COMMIT_O(commit), .BUSY_O(busy)
    );
    twr_host u_host (.io_i(io_line), .sclk_o(sclk), .cs_o(cs), .io_o(h_io));
    // Counted on the falling edge, where the pulse has settled.
    always @(negedge clk_sys)
        if (commit === 1'h1)
            commit_cnt++;
    function automatic logic [7:0] wv(input int a, input int i);
        return 8'(a * 8'h1D + i * 8'h07 + 8'h35);
    endfunction
    function automatic logic [`TWR_NUM_WR*8-1:0] exp_cfg();
        for (int i = 0; i < `TWR_NUM_WR; i++)
            exp_cfg[8*i +: 8] = mem[i];
    endfunction
    task automatic check(input string what,
        input logic [`TWR_NUM_WR*8-1:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic frame(input int a, input logic rd, input int n);
        int c0;
        c0 = commit_cnt;
        u_host.cs_set(1'h1);
        u_host.xfer({a[6:0], rd}, 1'h0, rx);
        for (int i = 0; i < n; i++) begin
            u_host.xfer(wv(a, i), rd, rx);
            if (rd)
                check("read byte", rx, mem[a + i]);
        end
        check("early commit", cfg, exp_cfg());
        check("line drive", io_oe, rd);
        u_host.cs_set(1'h0);
        check("line release", io_oe, 1'h0);
        for (int i = 0; i < n; i++)
            if (!rd && a + i < `TWR_NUM_WR)
                mem[a + i] = wv(a, i);
        repeat (8) @(posedge clk_sys);
        check("config", cfg, exp_cfg());
        check("commit pulse", commit_cnt - c0, 1);
        check("mode", mode, mem[0][2:1]);
    endtask
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        reset_n = 1'h0;
        fee = 8'hC6;
        for (int i = 0; i < 128; i++)
            mem[i] = (i == `TWR_NUM_WR) ? fee : 8'h00;
        repeat (6) @(posedge clk_sys);
        #1 reset_n = 1'h1;
        repeat (3) @(posedge clk_sys);
        check("mode at reset", mode, 2'h0);
        frame(0, 1'h0, 22);
        frame(20, 1'h0, 3);
        frame(100, 1'h0, 2);
        frame(0, 1'h1, 1);
        frame(19, 1'h1, 5);
        u_host.xfer(8'hFF, 1'h0, rx);
        repeat (8) @(posedge clk_sys);
        check("deselected", cfg, exp_cfg());
        frame(5, 1'h0, 3);
        frame(4, 1'h1, 4);
        print_verdict();
    end
    initial begin
        #300000;
        error_cnt++;
        print_verdict();
    end
endmodule // three_wire_register_port_bench
